// ### logic/sac_pkg.sv
// Shared constants, register map and state codes for the conversion sequencer
package sac_pkg;

  // ---------------------------------------------------------------
  // Converter geometry
  // ---------------------------------------------------------------
  localparam int RES_BITS = 8;
  localparam int CHAN_BITS = 3;
  localparam int CHAN_COUNT = 8;
  localparam logic [RES_BITS-1:0] RES_ALL_ONES = 8'hFF;
  localparam logic [RES_BITS-1:0] RES_ALL_ZEROS = 8'h00;
  localparam logic [RES_BITS-1:0] RESULT_RST = 8'h00;
  localparam logic [CHAN_BITS-1:0] CHAN_RST = 3'h0;
  localparam logic [2:0] MSB_INDEX = 3'h7;
  localparam logic [2:0] LSB_INDEX = 3'h0;

  // ---------------------------------------------------------------
  // Timing in converter clock periods
  // ---------------------------------------------------------------
  localparam int SAMPLE_PERIODS = 8;
  localparam int PERIODS_PER_BIT = 2;
  localparam int CONV_PERIODS = SAMPLE_PERIODS + PERIODS_PER_BIT * RES_BITS;
  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_PERIODS - 1);
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ONE = 4'h1;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 8'h10;

  localparam int CTRL_FREERUN_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int STATUS_DONE_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;
  localparam int STATUS_CHAN_LSB = 4;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ABORT_BIT = 1;
  localparam int INT_BITS = 2;
  localparam logic [INT_BITS-1:0] INT_RST = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic HRESP_OKAY = 1'h0;

  // ---------------------------------------------------------------
  // Sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HOLD = 5'h02,
    ST_SAMP = 5'h04,
    ST_TRY = 5'h08,
    ST_DEC = 5'h10
  } sac_state_e;

endpackage

// ### logic/sac_edge_det.sv
// Rising and falling edge detector for a synchronous input level
module sac_edge_det
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic level,
  output logic rise,
  output logic fall
);

  logic prev_r;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

endmodule

// ### logic/sac_ahb_slave.sv
// AHB-Lite zero-wait slave front end: decodes transfers into register strobes
module sac_ahb_slave
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic rdStrobe,
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  output logic wrStrobe,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData
);

  logic wrPend_r;
  logic [ADDR_W-1:0] wrAddr_r;
  logic [31:0] hrdata_r;
  logic addrPhase;

  // Only word transfers exist; hsize is accepted but not checked
  assign addrPhase = hsel & hready & htrans[1];
  assign rdStrobe = addrPhase & ~hwrite;
  assign rdAddr = haddr[ADDR_W-1:0];

  // Read data is captured at the address edge so it stands for the data phase
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= CTRL_OFS;
      hrdata_r <= WORD_ZERO;
    end else begin
      wrPend_r <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_r <= haddr[ADDR_W-1:0];
      end
      if (rdStrobe) begin
        hrdata_r <= rdData;
      end
    end
  end

  assign wrStrobe = wrPend_r;
  assign wrAddr = wrAddr_r;
  assign wrData = hwdata;
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

endmodule

// ### logic/sac_sequencer.sv
// Successive-approximation conversion sequencer with channel latch and bus registers
module sac_sequencer
  import sac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic convClk,
  input wire logic address_load_strobe,
  input wire logic [CHAN_BITS-1:0] channel_select_code,
  input wire logic conversion_start_pulse,
  input wire logic outputDriveEnable,
  input wire logic compAbove,
  input wire logic inputOverRange,
  input wire logic inputUnderRange,
  output logic [CHAN_COUNT-1:0] channelEnable,
  output logic sampleClosed,
  output logic [RES_BITS-1:0] weightOnRef,
  output logic conversionDone,
  output logic [RES_BITS-1:0] result_bits,
  output logic resultBitsOe,
  output logic irq
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rstSync1_r;
  logic rstSync2_r;
  logic rstN;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end

  assign rstN = rstSync2_r;

  // ---------------------------------------------------------------
  // Pin edges
  // ---------------------------------------------------------------
  logic startRise;
  logic startFall;
  logic alcRise;
  logic convTick;

  sac_edge_det uStartEdge (
    .clk(sys_clk),
    .rstN(rstN),
    .level(conversion_start_pulse),
    .rise(startRise),
    .fall(startFall)
  );

  sac_edge_det uAlcEdge (
    .clk(sys_clk),
    .rstN(rstN),
    .level(address_load_strobe),
    .rise(alcRise),
    .fall()
  );

  // One converter clock period ends on each rising edge of convClk
  sac_edge_det uConvEdge (
    .clk(sys_clk),
    .rstN(rstN),
    .level(convClk),
    .rise(convTick),
    .fall()
  );

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  logic rdStrobe;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic wrStrobe;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;

  sac_ahb_slave uBus (
    .clk(sys_clk),
    .rstN(rstN),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rdStrobe(rdStrobe),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .wrStrobe(wrStrobe),
    .wrAddr(wrAddr),
    .wrData(wrData)
  );

  // ---------------------------------------------------------------
  // Channel latch
  // ---------------------------------------------------------------
  logic [CHAN_BITS-1:0] chanCode_r;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      chanCode_r <= CHAN_RST;
    end else if (alcRise) begin
      chanCode_r <= channel_select_code;
    end
  end

  // Code 0 drives enable bit 0, which is analog input 1
  generate
    for (genvar g = 0; g < CHAN_COUNT; g++) begin : gChan
      assign channelEnable[g] = (chanCode_r == CHAN_BITS'(g));
    end
  endgenerate

  // ---------------------------------------------------------------
  // Software control
  // ---------------------------------------------------------------
  logic freeRun_r;
  logic softStart_r;
  logic [INT_BITS-1:0] intMask_r;
  logic wrCtrl;
  logic wrMask;

  assign wrCtrl = wrStrobe & (wrAddr == CTRL_OFS);
  assign wrMask = wrStrobe & (wrAddr == INT_MASK_OFS);

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      freeRun_r <= 1'b0;
      softStart_r <= 1'b0;
      intMask_r <= INT_RST;
    end else begin
      if (wrCtrl) begin
        freeRun_r <= wrData[CTRL_FREERUN_BIT];
      end
      softStart_r <= wrCtrl & wrData[CTRL_START_BIT];
      if (wrMask) begin
        intMask_r <= wrData[INT_BITS-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  sac_state_e state_r;
  sac_state_e state_nxt;
  logic [3:0] periodCnt_r;
  logic [2:0] bitIdx_r;
  logic [RES_BITS-1:0] trial_r;
  logic [RES_BITS-1:0] weights_r;
  logic [RES_BITS-1:0] resultLatch_r;
  logic done_r;
  logic kick_r;
  logic startReq;
  logic busy;
  logic finish;
  logic sampleEnd;
  logic [RES_BITS-1:0] bitMask;
  logic [RES_BITS-1:0] finalCode;

  // Free-run loops done back into start, but only after a first start
  assign startReq = startRise | softStart_r | kick_r;
  assign busy = (state_r != ST_IDLE);
  assign sampleEnd = (state_r == ST_SAMP) & convTick & (periodCnt_r == SAMPLE_LAST);
  assign finish = (state_r == ST_DEC) & convTick & (bitIdx_r == LSB_INDEX);
  assign bitMask = RES_BITS'(1) << bitIdx_r;
  assign finalCode = inputOverRange ? RES_ALL_ONES :
    (inputUnderRange ? RES_ALL_ZEROS :
    (compAbove ? (trial_r | bitMask) : trial_r));

  always_comb begin
    state_nxt = state_r;
    if (startReq) begin
      state_nxt = ST_HOLD;
    end else begin
      unique case (state_r)
        ST_IDLE: state_nxt = ST_IDLE;
        ST_HOLD: state_nxt = conversion_start_pulse ? ST_HOLD : ST_SAMP;
        ST_SAMP: state_nxt = sampleEnd ? ST_TRY : ST_SAMP;
        ST_TRY: state_nxt = convTick ? ST_DEC : ST_TRY;
        ST_DEC: state_nxt = convTick ? (finish ? ST_IDLE : ST_TRY) : ST_DEC;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Counters and capacitor switch states
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      periodCnt_r <= COUNT_ZERO;
      bitIdx_r <= MSB_INDEX;
      trial_r <= RESULT_RST;
      weights_r <= RESULT_RST;
    end else if (startReq || state_r == ST_HOLD) begin
      periodCnt_r <= COUNT_ZERO;
      bitIdx_r <= MSB_INDEX;
      trial_r <= RESULT_RST;
      weights_r <= RESULT_RST;
    end else if (convTick) begin
      if (state_r == ST_SAMP) begin
        periodCnt_r <= periodCnt_r + COUNT_ONE;
        if (sampleEnd) begin
          weights_r <= RES_BITS'(1) << MSB_INDEX;
        end
      end else if (state_r == ST_DEC) begin
        if (compAbove) begin
          trial_r <= trial_r | bitMask;
          weights_r <= (weights_r & ~bitMask) | (bitMask >> 1);
        end else begin
          weights_r <= weights_r | (bitMask >> 1);
        end
        if (!finish) begin
          bitIdx_r <= bitIdx_r - 3'h1;
        end
      end
    end
  end

  // Result latch and done flag
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      resultLatch_r <= RESULT_RST;
      done_r <= 1'b0;
      kick_r <= 1'b0;
    end else begin
      kick_r <= finish & freeRun_r;
      if (startReq) begin
        resultLatch_r <= RESULT_RST;
        done_r <= 1'b0;
      end else if (finish) begin
        resultLatch_r <= finalCode;
        done_r <= 1'b1;
      end
    end
  end

  // Sampling switch closes from start rise until the eighth period ends
  assign sampleClosed = (state_r == ST_HOLD) | (state_r == ST_SAMP);
  assign weightOnRef = weights_r;
  assign conversionDone = done_r;
  assign result_bits = resultLatch_r;
  assign resultBitsOe = outputDriveEnable;

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [INT_BITS-1:0] intStat_r;
  logic [INT_BITS-1:0] intSet;
  logic rdIntStat;

  assign intSet[INT_DONE_BIT] = finish;
  assign intSet[INT_ABORT_BIT] = startReq & busy;
  assign rdIntStat = rdStrobe & (rdAddr == INT_STAT_OFS);

  // A new event in the read cycle survives the clear
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      intStat_r <= INT_RST;
    end else begin
      intStat_r <= (rdIntStat ? INT_RST : intStat_r) | intSet;
    end
  end

  assign irq = |(intStat_r & intMask_r);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;

  assign ctrlWord = {31'h0000_0000, freeRun_r};
  assign statusWord = {{(32 - STATUS_CHAN_LSB - CHAN_BITS){1'b0}}, chanCode_r,
    {(STATUS_CHAN_LSB - 2){1'b0}}, busy, done_r};
  assign rdData = (rdAddr == CTRL_OFS) ? ctrlWord :
    (rdAddr == STATUS_OFS) ? statusWord :
    (rdAddr == RESULT_OFS) ? {24'h00_0000, resultLatch_r} :
    (rdAddr == INT_STAT_OFS) ? {30'h0000_0000, intStat_r} :
    (rdAddr == INT_MASK_OFS) ? {30'h0000_0000, intMask_r} : WORD_ZERO;

endmodule

// ### test/sac_sequencer_assertions.sv
// Port-level assertions for the conversion sequencer
module sac_sequencer_chk
  import sac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic convClk,
  input wire logic address_load_strobe,
  input wire logic [CHAN_BITS-1:0] channel_select_code,
  input wire logic conversion_start_pulse,
  input wire logic outputDriveEnable,
  input wire logic [CHAN_COUNT-1:0] channelEnable,
  input wire logic sampleClosed,
  input wire logic [RES_BITS-1:0] weightOnRef,
  input wire logic conversionDone,
  input wire logic [RES_BITS-1:0] result_bits,
  input wire logic resultBitsOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ----------------
  // Helpers
  // ----------------
  // Saturates so that a done which never comes cannot wrap into a match
  logic [4:0] periods_r;
  logic [2:0] age_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      periods_r <= 5'h00;
      age_r <= 3'h0;
    end else begin
      if (age_r != 3'h7) age_r <= age_r + 3'h1;
      if ($fell(conversion_start_pulse) || $fell(conversionDone)) periods_r <= 5'h00;
      else if ($rose(convClk) && periods_r != 5'h1F) periods_r <= periods_r + 5'h01;
    end
  end
  // ----------------
  // Properties
  // ----------------
  chan_latch_a: assert property (
    $rose(address_load_strobe) |-> ##3 channelEnable == (8'h01 << channel_select_code))
    else $error("channel not latched");
  chan_hold_a: assert property (
    (age_r == 3'h7 && !address_load_strobe)[*4] |-> $stable(channelEnable))
    else $error("channel moved without strobe");
  start_clear_a: assert property (
    $rose(conversion_start_pulse) |-> ##[1:3] result_bits == 8'h00)
    else $error("result not cleared");
  done_low_a: assert property (
    $rose(conversion_start_pulse) |-> ##[1:3] !conversionDone)
    else $error("done not dropped");
  conv_len_a: assert property (
    $rose(conversionDone) |-> periods_r == 5'h18 && !sampleClosed)
    else $error("conversion length wrong");
  msb_first_a: assert property (
    $fell(sampleClosed) && !conversionDone |-> ##[0:1] weightOnRef == 8'h80)
    else $error("top weight not tested first");
  no_partial_a: assert property (
    (!conversionDone)[*3] |-> result_bits == 8'h00)
    else $error("result shown before done");
  drive_en_a: assert property (
    resultBitsOe == outputDriveEnable)
    else $error("drive does not follow enable");
endmodule

bind sac_sequencer sac_sequencer_chk u_chk (.sys_clk, .arst_n, .convClk,
  .address_load_strobe, .channel_select_code, .conversion_start_pulse,
  .outputDriveEnable, .channelEnable, .sampleClosed, .weightOnRef,
  .conversionDone, .result_bits, .resultBitsOe);

// ### test/sac_comp_model.sv
// Comparator model of the charge node on the converter side
module sac_comp_model
  import sac_pkg::*;
(
  input wire logic [RES_BITS-1:0] weightOnRef,
  input wire logic [RES_BITS-1:0] vin,
  output logic compAbove
);
  logic [RES_BITS-1:0] tested;
  logic [RES_BITS-1:0] trial;
  // Lowest weight on the reference is the one under test
  assign tested = weightOnRef & (~weightOnRef + 8'h01);
  // Grounded weights above it are the bits already kept
  assign trial = (~weightOnRef & ~((tested << 1) - 8'h01)) | tested;
  assign compAbove = (vin >= trial);
endmodule

// ### test/sar_adc_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
module sar_adc_conversion_sequencer_tb
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = HTRANS_IDLE;
  logic [1:0] cc = 2'h0;
  logic address_load_strobe = 1'b0;
  logic conversion_start_pulse = 1'b0;
  logic outputDriveEnable = 1'b0;
  logic inputOverRange = 1'b0;
  logic inputUnderRange = 1'b0;
  logic [2:0] channel_select_code = 3'h0;
  logic [7:0] vin = 8'h00;
  logic hreadyout, hresp, compAbove, sampleClosed, conversionDone, resultBitsOe, irq, convClk;
  logic [31:0] hrdata, rd;
  logic [7:0] channelEnable, weightOnRef, result_bits;
  int fail_count = 0;
  int n_tests = 0;
  int n;
  logic prevDone;
  // Code, input, over and under flags, expected result
  logic [20:0] rows [8] = '{{3'h0, 8'h00, 2'h0, 8'h00}, {3'h1, 8'hFF, 2'h0, 8'hFF},
    {3'h2, 8'h80, 2'h0, 8'h80}, {3'h3, 8'h7F, 2'h0, 8'h7F}, {3'h4, 8'h55, 2'h0, 8'h55},
    {3'h5, 8'hAA, 2'h0, 8'hAA}, {3'h6, 8'h12, 2'h2, 8'hFF}, {3'h7, 8'h34, 2'h1, 8'h00}};

  initial forever #12.5 sys_clk = ~sys_clk;
  // Converter clock at a quarter rate so the design always sees each edge
  always @(posedge sys_clk) cc <= cc + 2'h1;
  assign convClk = cc[1];

  sac_sequencer dut (.sys_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .convClk,
    .address_load_strobe, .channel_select_code, .conversion_start_pulse,
    .outputDriveEnable, .compAbove, .inputOverRange, .inputUnderRange, .channelEnable,
    .sampleClosed, .weightOnRef, .conversionDone, .result_bits, .resultBitsOe, .irq);
  sac_comp_model far (.weightOnRef, .vin, .compAbove);

  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rdy(inout int k);
    do begin
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(32'h0, 32'h1);
      stop_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    rdy(k);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    rdy(k);
    rd = hrdata;
    chk(hresp, HRESP_OKAY);
  endtask
  // Start edges are kept clear of converter clock rising edges, so counts are exact
  task automatic align(input logic [1:0] ph);
    @(negedge sys_clk);
    for (int k = 0; k < 8 && cc !== ph; k++) @(negedge sys_clk);
    if (cc !== ph) begin
      chk(cc, ph);
      stop_test();
    end
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 400 && conversionDone !== 1'b1; k++) @(negedge sys_clk);
    if (k == 400) begin
      chk(32'h0, 32'h1);
      stop_test();
    end
  endtask
  task automatic pulse();
    align(2'h2);
    @(posedge sys_clk);
    conversion_start_pulse <= 1'b1;
    @(posedge sys_clk);
    conversion_start_pulse <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic conv(input logic [2:0] c, input logic [7:0] v, input logic ov,
      input logic un, input logic [7:0] exp);
    @(posedge sys_clk);
    channel_select_code <= c;
    vin <= v;
    inputOverRange <= ov;
    inputUnderRange <= un;
    @(posedge sys_clk);
    address_load_strobe <= 1'b1;
    repeat (4) @(posedge sys_clk);
    address_load_strobe <= 1'b0;
    chk(channelEnable, 32'h1 << c);
    pulse();
    chk(result_bits, RESULT_RST);
    chk(conversionDone, 1'b0);
    wait_done();
    chk(result_bits, exp);
  endtask

  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(result_bits, RESULT_RST);
    bus(1'b0, INT_MASK_OFS, WORD_ZERO);
    chk(rd, WORD_ZERO);
    for (int i = 0; i < 8; i++) begin
      outputDriveEnable <= i[0];
      conv(rows[i][20:18], rows[i][17:10], rows[i][9], rows[i][8], rows[i][7:0]);
      chk(resultBitsOe, i[0]);
      bus(1'b0, RESULT_OFS, WORD_ZERO);
      chk(rd, rows[i][7:0]);
      bus(1'b0, STATUS_OFS, WORD_ZERO);
      chk(rd, (32'(rows[i][20:18]) << STATUS_CHAN_LSB) | (32'h1 << STATUS_DONE_BIT));
    end
    chk(irq, 1'b0);
    bus(1'b1, INT_MASK_OFS, 32'h3);
    @(negedge sys_clk);
    chk(irq, 1'b1);
    bus(1'b0, INT_STAT_OFS, WORD_ZERO);
    chk(rd, 32'h1);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    pulse();
    repeat (40) @(posedge sys_clk);
    conv(3'h2, 8'h3C, 1'b0, 1'b0, 8'h3C);
    bus(1'b0, INT_STAT_OFS, WORD_ZERO);
    chk(rd, 32'h3);
    align(2'h0);
    bus(1'b1, CTRL_OFS, 32'h2);
    repeat (3) @(posedge sys_clk);
    wait_done();
    chk(result_bits, 8'h3C);
    bus(1'b0, CTRL_OFS, WORD_ZERO);
    chk(rd, WORD_ZERO);
    bus(1'b0, 8'h20, WORD_ZERO);
    chk(rd, WORD_ZERO);
    bus(1'b1, CTRL_OFS, 32'h1);
    bus(1'b0, CTRL_OFS, WORD_ZERO);
    chk(rd, 32'h1 << CTRL_FREERUN_BIT);
    pulse();
    n = 0;
    prevDone = conversionDone;
    // Count rising edges only, so a done that sticks high cannot pass
    for (int k = 0; k < 300; k++) begin
      @(negedge sys_clk);
      if (conversionDone === 1'b1 && prevDone !== 1'b1) n++;
      prevDone = conversionDone;
    end
    chk(n >= 2, 1'b1);
    bus(1'b1, CTRL_OFS, WORD_ZERO);
    repeat (3) @(posedge sys_clk);
    wait_done();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    @(negedge sys_clk);
    chk(conversionDone, 1'b0);
    chk(result_bits, RESULT_RST);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    conv(3'h5, 8'hC3, 1'b0, 1'b0, 8'hC3);
    stop_test();
  end
endmodule
